// ### delr_pkg.sv
// package of constants for the drive error log recorder
package delr_pkg;
  // ----------------------------------------------------------------
  // log addresses and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] LOG_WRITE_STREAM = 8'h21;
  localparam logic [7:0] LOG_READ_STREAM  = 8'h22;
  localparam logic [7:0] LOG_QUEUED       = 8'h10;
  localparam logic [7:0] LOG_DEV_CONFIG   = 8'h30;
  localparam logic [7:0] STREAM_VERSION   = 8'h02;
  localparam logic [4:0] MAX_ENTRIES      = 5'h1F;
  localparam logic [8:0] ENTRY_BASE       = 9'h010;
  localparam logic [8:0] LAST_BYTE        = 9'h1FF;
  localparam logic [8:0] QREC_RSVD_START  = 9'h017;
  localparam logic [7:0] CFG_LAST_PAGE    = 8'h08;
  localparam logic [7:0] CFG_PATA_PAGE    = 8'h07;
  localparam logic [7:0] FEAT_DEFERRED    = 8'hFF;
  localparam logic [15:0] CFG_REVISION    = 16'h0001;

  // ----------------------------------------------------------------
  // read engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_SEND = 2'b01,
    RD_SUM  = 2'b11
  } delr_rd_type;
endpackage : delr_pkg

// ### delr_stream_log.sv
// one stream error log: 31 circular entries, index and saturating count
module delr_stream_log #(
  parameter logic [4:0] IDX_MIN = 5'h01
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // error capture
  input  wire logic        add_i,
  input  wire logic        deferred_i,
  input  wire logic [7:0]  feat_cur_i,
  input  wire logic [7:0]  feat_prev_i,
  input  wire logic [7:0]  status_i,
  input  wire logic [7:0]  error_i,
  input  wire logic [47:0] lba_i,
  input  wire logic [15:0] count_i,
  // clear after a good log read
  input  wire logic        clear_i,
  // byte read port
  input  wire logic [8:0]  rd_addr_i,
  output logic      [7:0]  rd_data_o,
  output logic      [4:0]  index_o,
  output logic      [15:0] count_o
);
  logic [7:0]  ent_mem [0:30][0:15];
  logic [4:0]  index;
  logic [15:0] count;
  logic [4:0]  next_index;
  logic [15:0] next_count;
  logic [4:0]  slot;
  logic [3:0]  ent_off;
  logic [4:0]  ent_no;
  // newest slot before the index wraps back to the first one
  localparam logic [4:0] IDX_LAST = delr_pkg::MAX_ENTRIES - 5'h01 + IDX_MIN;

  always_comb begin
    next_index = index;
    next_count = count;
    if (clear_i) begin
      next_index = 5'h00;
      next_count = 16'h0000;
    end else if (add_i) begin
      if (count == 16'h0000 || index == IDX_LAST) begin
        next_index = IDX_MIN;
      end else begin
        next_index = index + 5'h01;
      end
      if (count != 16'hFFFF) begin
        next_count = count + 16'h0001;
      end
    end
  end

  // slot written is the one the new index names
  assign slot = (IDX_MIN == 5'h01) ? next_index - 5'h01 : next_index;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      index <= 5'h00;
      count <= 16'h0000;
    end else begin
      index <= next_index;
      count <= next_count;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (add_i && !clear_i && slot < delr_pkg::MAX_ENTRIES) begin
      ent_mem[slot][0]  <= deferred_i ? delr_pkg::FEAT_DEFERRED : feat_cur_i;
      ent_mem[slot][1]  <= deferred_i ? delr_pkg::FEAT_DEFERRED : feat_prev_i;
      ent_mem[slot][2]  <= status_i;
      ent_mem[slot][3]  <= error_i;
      ent_mem[slot][4]  <= lba_i[7:0];
      ent_mem[slot][5]  <= lba_i[15:8];
      ent_mem[slot][6]  <= lba_i[23:16];
      ent_mem[slot][7]  <= lba_i[31:24];
      ent_mem[slot][8]  <= lba_i[39:32];
      ent_mem[slot][9]  <= lba_i[47:40];
      ent_mem[slot][10] <= 8'h00;
      ent_mem[slot][11] <= 8'h00;
      ent_mem[slot][12] <= count_i[7:0];
      ent_mem[slot][13] <= count_i[15:8];
      ent_mem[slot][14] <= 8'h00;
      ent_mem[slot][15] <= 8'h00;
    end
  end

  assign ent_no  = rd_addr_i[8:4] - 5'h01;
  assign ent_off = rd_addr_i[3:0];

  always_comb begin
    rd_data_o = 8'h00;
    unique case (rd_addr_i)
      9'h000:  rd_data_o = delr_pkg::STREAM_VERSION;
      9'h001:  rd_data_o = {3'b000, index};
      9'h002:  rd_data_o = count[7:0];
      9'h003:  rd_data_o = count[15:8];
      default: begin
        // entries not yet written since clear read as zero
        if (rd_addr_i >= delr_pkg::ENTRY_BASE && ent_no < count) begin
          rd_data_o = ent_mem[ent_no][ent_off];
        end
      end
    endcase
  end

  assign index_o = index;
  assign count_o = count;

  index_wrap_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    add_i && !clear_i |=> index >= IDX_MIN && index <= IDX_LAST)
    else $error("stream log index out of range");
endmodule : delr_stream_log

// ### delr_top.sv
// drive error log recorder: queued record, stream logs, configuration page index
// Summary of operation
// - queued tag in byte zero low bits
// - byte zero bit seven marks non-queued
// - bytes two to thirteen shadow snapshot
// - fixed queued record byte layout
// - last byte makes sum zero
// - stream entry only with error flag
// - 512-byte logs keep 31 newest
// - read stream count saturates
// - good read of 22h clears read log
// - reset clears stream logs
// - stream header then 16-byte entries
// - stream version byte is 02h
// - read index 1 to 31
// - entry field byte layout
// - deferred write feature bytes all ones
// - entry gives start and sector count
// - good read of 21h clears write log
// - write stream count saturates
// - write index 0 to 30
// - config log read-only, zero revision unsupported
// - config pages 00h to 08h, except 07h
module delr_top (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // error report from the command layer
  input  wire logic        err_valid_i,
  input  wire logic        err_queued_i,
  input  wire logic [4:0]  err_tag_i,
  input  wire logic        err_unload_i,
  input  wire logic [7:0]  err_feat_cur_i,
  input  wire logic [7:0]  err_feat_prev_i,
  input  wire logic [7:0]  err_status_i,
  input  wire logic [7:0]  err_error_i,
  input  wire logic [7:0]  err_device_i,
  input  wire logic [47:0] err_lba_i,
  input  wire logic [15:0] err_count_i,
  input  wire logic [7:0]  err_sense_key_i,
  input  wire logic [7:0]  err_asc_i,
  input  wire logic [7:0]  err_ascq_i,
  input  wire logic [47:0] err_final_lba_i,
  input  wire logic        stream_error_flag_i,
  input  wire logic        stream_write_i,
  input  wire logic        deferred_write_i,
  // log read request
  input  wire logic        log_req_i,
  input  wire logic [7:0]  log_addr_i,
  input  wire logic [7:0]  log_page_i,
  input  wire logic        log_done_ok_i,
  // byte stream out
  output logic             log_valid_o,
  output logic [7:0]       log_data_o,
  output logic             log_last_o,
  output logic             log_busy_o,
  // status
  output logic [4:0]       rd_index_o,
  output logic [15:0]      rd_count_o,
  output logic [4:0]       wr_index_o,
  output logic [15:0]      wr_count_o
);
  // ----------------------------------------------------------------
  // queued error record
  // ----------------------------------------------------------------
  logic [7:0]  qrec [0:22];
  logic [7:0]  next_qrec [0:22];

  always_comb begin
    for (int i = 0; i < 23; i++) begin
      next_qrec[i] = qrec[i];
    end
    if (err_valid_i) begin
      next_qrec[0]  = {!err_queued_i, err_unload_i, 1'b0,
                       err_queued_i ? err_tag_i : 5'h00};
      next_qrec[1]  = 8'h00;
      next_qrec[2]  = err_status_i;
      next_qrec[3]  = err_error_i;
      next_qrec[4]  = err_lba_i[7:0];
      next_qrec[5]  = err_lba_i[15:8];
      next_qrec[6]  = err_lba_i[23:16];
      next_qrec[7]  = err_device_i;
      next_qrec[8]  = err_lba_i[31:24];
      next_qrec[9]  = err_lba_i[39:32];
      next_qrec[10] = err_lba_i[47:40];
      next_qrec[11] = 8'h00;
      next_qrec[12] = err_count_i[7:0];
      next_qrec[13] = err_count_i[15:8];
      next_qrec[14] = err_sense_key_i;
      next_qrec[15] = err_asc_i;
      next_qrec[16] = err_ascq_i;
      next_qrec[17] = err_final_lba_i[7:0];
      next_qrec[18] = err_final_lba_i[15:8];
      next_qrec[19] = err_final_lba_i[23:16];
      next_qrec[20] = err_final_lba_i[31:24];
      next_qrec[21] = err_final_lba_i[39:32];
      next_qrec[22] = err_final_lba_i[47:40];
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 23; i++) begin
      if (rst_i) begin
        qrec[i] <= 8'h00;
      end else begin
        qrec[i] <= next_qrec[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // stream logs
  // ----------------------------------------------------------------
  logic [8:0] rd_ptr;
  logic [7:0] rs_byte;
  logic [7:0] ws_byte;
  logic       rs_add;
  logic       ws_add;
  logic       rs_clear;
  logic       ws_clear;
  logic [7:0] cur_addr;

  // entry only with stream error flag
  assign rs_add = err_valid_i && stream_error_flag_i && !stream_write_i;
  assign ws_add = err_valid_i && stream_error_flag_i && stream_write_i;
  // clear after good read of 22h
  assign rs_clear = log_done_ok_i && cur_addr == delr_pkg::LOG_READ_STREAM;
  // clear after good read of 21h
  assign ws_clear = log_done_ok_i && cur_addr == delr_pkg::LOG_WRITE_STREAM;

  delr_stream_log #(.IDX_MIN(5'h01)) u_read_log (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .add_i       (rs_add),
    .deferred_i  (1'b0),
    .feat_cur_i  (err_feat_cur_i),
    .feat_prev_i (err_feat_prev_i),
    .status_i    (err_status_i),
    .error_i     (err_error_i),
    .lba_i       (err_lba_i),
    .count_i     (err_count_i),
    .clear_i     (rs_clear),
    .rd_addr_i   (rd_ptr),
    .rd_data_o   (rs_byte),
    .index_o     (rd_index_o),
    .count_o     (rd_count_o)
  );

  delr_stream_log #(.IDX_MIN(5'h00)) u_write_log (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .add_i       (ws_add),
    .deferred_i  (deferred_write_i),
    .feat_cur_i  (err_feat_cur_i),
    .feat_prev_i (err_feat_prev_i),
    .status_i    (err_status_i),
    .error_i     (err_error_i),
    .lba_i       (err_lba_i),
    .count_i     (err_count_i),
    .clear_i     (ws_clear),
    .rd_addr_i   (rd_ptr),
    .rd_data_o   (ws_byte),
    .index_o     (wr_index_o),
    .count_o     (wr_count_o)
  );

  // ----------------------------------------------------------------
  // configuration log page index
  // ----------------------------------------------------------------
  logic [7:0] cur_page;
  logic [7:0] cfg_byte;

  // read-only headers, pages 00h to 08h except 07h
  always_comb begin
    cfg_byte = 8'h00;
    if (cur_page <= delr_pkg::CFG_LAST_PAGE && cur_page != delr_pkg::CFG_PATA_PAGE) begin
      unique case (rd_ptr)
        9'h000:  cfg_byte = delr_pkg::CFG_REVISION[7:0];
        9'h001:  cfg_byte = delr_pkg::CFG_REVISION[15:8];
        9'h002:  cfg_byte = cur_page;
        9'h008:  cfg_byte = (cur_page == 8'h00) ? 8'h08 : 8'h00;
        default: begin
          if (cur_page == 8'h00 && rd_ptr >= 9'h009 && rd_ptr <= 9'h010) begin
            cfg_byte = (rd_ptr[7:0] - 8'h09 < delr_pkg::CFG_PATA_PAGE) ?
                       rd_ptr[7:0] - 8'h09 : rd_ptr[7:0] - 8'h08;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read engine
  // ----------------------------------------------------------------
  delr_pkg::delr_rd_type state;
  delr_pkg::delr_rd_type next_state;
  logic [8:0] next_rd_ptr;
  logic [7:0] next_cur_addr;
  logic [7:0] next_cur_page;
  logic [7:0] sum;
  logic [7:0] next_sum;
  logic [7:0] src_byte;
  logic       next_valid;
  logic [7:0] next_data;
  logic       next_last;

  always_comb begin
    unique case (cur_addr)
      delr_pkg::LOG_READ_STREAM:  src_byte = rs_byte;
      delr_pkg::LOG_WRITE_STREAM: src_byte = ws_byte;
      delr_pkg::LOG_DEV_CONFIG:   src_byte = cfg_byte;
      delr_pkg::LOG_QUEUED: begin
        src_byte = (rd_ptr < delr_pkg::QREC_RSVD_START) ? qrec[rd_ptr[4:0]] : 8'h00;
      end
      default:                    src_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_state    = state;
    next_rd_ptr   = rd_ptr;
    next_cur_addr = cur_addr;
    next_cur_page = cur_page;
    next_sum      = sum;
    next_valid    = 1'b0;
    next_data     = 8'h00;
    next_last     = 1'b0;
    unique case (state)
      delr_pkg::RD_IDLE: begin
        if (log_req_i) begin
          next_state    = delr_pkg::RD_SEND;
          next_rd_ptr   = 9'h000;
          next_cur_addr = log_addr_i;
          next_cur_page = log_page_i;
          next_sum      = 8'h00;
        end
      end
      delr_pkg::RD_SEND: begin
        next_valid = 1'b1;
        if (rd_ptr == delr_pkg::LAST_BYTE) begin
          next_data  = (cur_addr == delr_pkg::LOG_QUEUED) ? 8'h00 - sum : src_byte;
          next_last  = 1'b1;
          next_state = delr_pkg::RD_SUM;
        end else begin
          next_data   = src_byte;
          next_sum    = sum + src_byte;
          next_rd_ptr = rd_ptr + 9'h001;
        end
      end
      delr_pkg::RD_SUM: begin
        next_state = delr_pkg::RD_IDLE;
      end
      default: begin
        next_state = delr_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state       <= delr_pkg::RD_IDLE;
      rd_ptr      <= 9'h000;
      cur_addr    <= 8'h00;
      cur_page    <= 8'h00;
      sum         <= 8'h00;
      log_valid_o <= 1'b0;
      log_data_o  <= 8'h00;
      log_last_o  <= 1'b0;
      log_busy_o  <= 1'b0;
    end else begin
      state       <= next_state;
      rd_ptr      <= next_rd_ptr;
      cur_addr    <= next_cur_addr;
      cur_page    <= next_cur_page;
      sum         <= next_sum;
      log_valid_o <= next_valid;
      log_data_o  <= next_data;
      log_last_o  <= next_last;
      log_busy_o  <= next_state != delr_pkg::RD_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // saturation holds
  read_count_sat_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rd_count_o == 16'hFFFF && !rs_clear |=> rd_count_o == 16'hFFFF)
    else $error("read stream count left saturation");
  write_count_sat_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_count_o == 16'hFFFF && !ws_clear |=> wr_count_o == 16'hFFFF)
    else $error("write stream count left saturation");
  read_log_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rs_clear |=> rd_index_o == 5'h00 && rd_count_o == 16'h0000)
    else $error("read stream log not cleared");
  write_log_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ws_clear |=> wr_index_o == 5'h00 && wr_count_o == 16'h0000)
    else $error("write stream log not cleared");
  stream_add_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !stream_error_flag_i && !rs_clear |=> $stable(rd_count_o))
    else $error("read stream count moved without flag");
  read_index_rng_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rs_add && !rs_clear |=> rd_index_o >= 5'h01 && rd_index_o <= 5'h1F)
    else $error("read stream index out of range");
  nq_flag_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    err_valid_i && !err_queued_i |=> qrec[0][7] && qrec[0][4:0] == 5'h00)
    else $error("non-queued flag wrong");
  queued_tag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    err_valid_i && err_queued_i |=> qrec[0][4:0] == $past(err_tag_i) && !qrec[0][7])
    else $error("queued tag not captured");
  logic [9:0] rd_len, next_rd_len;
  always_comb begin
    next_rd_len = (rd_len == 10'h000 || rd_len == 10'h200) ? 10'h000 : rd_len + 10'h001;
    if (state == delr_pkg::RD_IDLE && log_req_i) begin
      next_rd_len = 10'h001;
    end
  end
  always_ff @(posedge core_clk_i) rd_len <= rst_i ? 10'h000 : next_rd_len;
  read_length_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_len == 10'h200) == next_last)
    else $error("log read not 512 bytes");
endmodule : delr_top

// ### delr_host_model.sv
// host model that issues log reads and gathers the returned bytes
module delr_host_model (
  // clock
  input  wire logic       core_clk_i,
  // byte stream in
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  // read request out
  output logic            req_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      page_o,
  output logic            ok_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx [512];
  int         n_rx;
  initial begin
    req_o  = 1'b0;
    addr_o = 8'h00;
    page_o = 8'h00;
    ok_o   = 1'b0;
  end
  // one read; address lines flip once the request is taken
  task automatic read_log(input logic [7:0] a, input logic [7:0] p, input logic ok);
    int k;
    n_rx   = 0;
    k      = 0;
    @(negedge core_clk_i);
    req_o  = 1'b1;
    addr_o = a;
    page_o = p;
    @(negedge core_clk_i);
    req_o  = 1'b0;
    addr_o = ~a;
    page_o = ~p;
    while (k < 600) begin
      @(negedge core_clk_i);
      k++;
      if (valid_i) begin
        rx[n_rx % 512] = data_i;
        n_rx++;
        if (last_i) k = 600;
      end
    end
    @(negedge core_clk_i);
    ok_o = ok;
    @(negedge core_clk_i);
    ok_o = 1'b0;
  endtask
endmodule // delr_host_model

// ### delr_top_test.sv
// self-checking bench for the drive error log recorder
module delr_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i, rst_i, err_valid, err_queued, err_unload;
  logic        se, s_wr, dfr, req, ok, v_o, l_o, b_o;
  logic [4:0]  err_tag, rd_index, wr_index;
  logic [7:0]  fcur, fprev, stat, errb, dev, skey, asc, ascq, d_o, addr, page;
  logic [47:0] lba, flba;
  logic [15:0] cnt, rd_count, wr_count;
  logic [7:0]  rent [31][16];
  logic [7:0]  went [31][16];
  logic [7:0]  qrec [23];
  int          rcnt, wcnt, rpos, wpos, n_errors, check_count;
  integer      seed;

  delr_top dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .err_valid_i(err_valid),
    .err_queued_i(err_queued), .err_tag_i(err_tag), .err_unload_i(err_unload),
    .err_feat_cur_i(fcur), .err_feat_prev_i(fprev), .err_status_i(stat),
    .err_error_i(errb), .err_device_i(dev), .err_lba_i(lba), .err_count_i(cnt),
    .err_sense_key_i(skey), .err_asc_i(asc), .err_ascq_i(ascq),
    .err_final_lba_i(flba), .stream_error_flag_i(se), .stream_write_i(s_wr),
    .deferred_write_i(dfr), .log_req_i(req), .log_addr_i(addr), .log_page_i(page),
    .log_done_ok_i(ok), .log_valid_o(v_o), .log_data_o(d_o), .log_last_o(l_o),
    .log_busy_o(b_o), .rd_index_o(rd_index), .rd_count_o(rd_count),
    .wr_index_o(wr_index), .wr_count_o(wr_count));
  delr_host_model host_u (
    .core_clk_i(core_clk_i), .valid_i(v_o), .data_i(d_o), .last_i(l_o),
    .req_o(req), .addr_o(addr), .page_o(page), .ok_o(ok));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // comparison and model
  // ----------------------------------------------------------------
  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_byte(input int k, input logic [7:0] m, input logic [7:0] e,
                          input logic [7:0] g);
    check_count++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("mismatch byte %0d expected %h seen %h", k, e, g);
    end
  endtask
  task automatic clr_log(input logic r);
    for (int i = 0; i < 31; i++) begin
      for (int j = 0; j < 16; j++) begin
        if (r) rent[i][j] = 8'h00;
        else went[i][j] = 8'h00;
      end
    end
    if (r) rpos = 0;
    else wpos = 0;
    if (r) rcnt = 0;
    else wcnt = 0;
  endtask
  task automatic chk_stat();
    int wi;
    wi = (wpos == 0) ? 0 : wpos - 1;
    chk_val("rd_index", rpos[15:0], {11'h000, rd_index});
    chk_val("rd_count", rcnt[15:0], rd_count);
    chk_val("wr_index", wi[15:0], {11'h000, wr_index});
    chk_val("wr_count", wcnt[15:0], wr_count);
  endtask
  // one error report, held until the next report or quiet
  task automatic put_err(input logic s, input logic w, input logic q);
    logic [191:0] r;
    logic [7:0]   e [16];
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
         $random(seed)};
    @(negedge core_clk_i);
    {err_tag, err_unload, fcur, fprev, stat, errb, dev} = r[45:0];
    {lba, cnt} = r[109:46];
    {skey, asc, ascq, flba} = r[181:110];
    dfr = r[191];
    {err_queued, se, s_wr, err_valid} = {q, s, w, 1'b1};
    qrec = '{default: 8'h00};
    qrec[0] = {~q, err_unload, 1'b0, q ? err_tag : 5'h00};
    {qrec[3], qrec[2], qrec[7]} = {errb, stat, dev};
    {qrec[10], qrec[9], qrec[8], qrec[6], qrec[5], qrec[4]} = lba;
    {qrec[16], qrec[15], qrec[14], qrec[13], qrec[12]} = {ascq, asc, skey, cnt};
    {qrec[22], qrec[21], qrec[20], qrec[19], qrec[18], qrec[17]} = flba;
    e = '{default: 8'h00};
    {e[1], e[0]} = (w && dfr) ? 16'hFFFF : {fprev, fcur};
    {e[3], e[2], e[13], e[12]} = {errb, stat, cnt};
    {e[9], e[8], e[7], e[6], e[5], e[4]} = lba;
    if (s && w) begin
      wpos = wpos % 31 + 1;
      went[wpos - 1] = e;
      wcnt = (wcnt < 65535) ? wcnt + 1 : wcnt;
    end else if (s) begin
      rpos = rpos % 31 + 1;
      rent[rpos - 1] = e;
      rcnt = (rcnt < 65535) ? rcnt + 1 : rcnt;
    end
  endtask
  task automatic quiet();
    @(negedge core_clk_i);
    err_valid = 1'b0;
  endtask
  function automatic logic [15:0] exp_byte(input logic [7:0] a, input logic [7:0] p, int k);
    logic [7:0] s;
    int         c, xi;
    logic       wr;
    s = 8'h00;
    if (a == delr_pkg::LOG_QUEUED) begin
      for (int i = 0; i < 23; i++) s = s - qrec[i];
      if (k == 511) return {8'hFF, s};
      return {8'hFF, (k < 23) ? qrec[k] : 8'h00};
    end
    if (a == delr_pkg::LOG_READ_STREAM || a == delr_pkg::LOG_WRITE_STREAM) begin
      wr = (a == delr_pkg::LOG_WRITE_STREAM);
      c = wr ? wcnt : rcnt;
      xi = wr ? ((wpos == 0) ? 0 : wpos - 1) : rpos;
      if (k == 0) return {8'hFF, delr_pkg::STREAM_VERSION};
      if (k == 1) return {8'hFF, xi[7:0]};
      if (k < 4) return {8'hFF, (k == 2) ? c[7:0] : c[15:8]};
      if (k < 16) return 16'hFF00;
      return {8'hFF, wr ? went[k / 16 - 1][k % 16] : rent[k / 16 - 1][k % 16]};
    end
    if (a == delr_pkg::LOG_DEV_CONFIG && p != delr_pkg::CFG_PATA_PAGE &&
        p <= delr_pkg::CFG_LAST_PAGE) begin
      xi = k - 9;
      if (k < 3) return {8'hFF, (k == 0) ? 8'h01 : ((k == 1) ? 8'h00 : p)};
      if (p == 8'h00 && k == 8) return 16'hFF08;
      if (p == 8'h00 && k > 8 && k < 17) return {8'hFF, (k < 16) ? xi[7:0] : 8'h08};
      return 16'hFF00;
    end
    return 16'hFF00;
  endfunction
  task automatic chk_log(input logic [7:0] a, input logic [7:0] p, input logic ok_in);
    logic [15:0] x;
    host_u.read_log(a, p, ok_in);
    chk_val("byte count", 16'h0200, host_u.n_rx[15:0]);
    for (int k = 0; k < 512; k++) begin
      x = exp_byte(a, p, k);
      chk_byte(k, x[15:8], x[7:0], host_u.rx[k]);
    end
    if (ok_in && a == delr_pkg::LOG_READ_STREAM) clr_log(1'b1);
    if (ok_in && a == delr_pkg::LOG_WRITE_STREAM) clr_log(1'b0);
    chk_stat();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge core_clk_i);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    seed = 32'hEB79B09C;
    {err_valid, err_queued, err_unload, se, s_wr, dfr, err_tag} = 11'h000;
    {fcur, fprev, stat, errb, dev, skey, asc, ascq, lba, flba, cnt} = 0;
    rst_i = 1'b1;
    clr_log(1'b1);
    clr_log(1'b0);
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk_stat();
    chk_log(delr_pkg::LOG_READ_STREAM, 8'h00, 1'b0);
    chk_log(delr_pkg::LOG_WRITE_STREAM, 8'h00, 1'b0);
    repeat (40) put_err(1'b1, 1'b0, 1'b1);
    repeat (3) put_err(1'b1, 1'b1, 1'b1);
    put_err(1'b0, 1'b0, 1'b1);
    quiet();
    chk_stat();
    chk_log(delr_pkg::LOG_QUEUED, 8'h00, 1'b0);
    chk_log(delr_pkg::LOG_READ_STREAM, 8'h00, 1'b0);
    chk_log(delr_pkg::LOG_READ_STREAM, 8'h00, 1'b1);
    chk_log(delr_pkg::LOG_READ_STREAM, 8'h00, 1'b0);
    chk_log(delr_pkg::LOG_WRITE_STREAM, 8'h00, 1'b1);
    put_err(1'b1, 1'b1, 1'b0);
    quiet();
    chk_log(delr_pkg::LOG_QUEUED, 8'h00, 1'b0);
    for (int p = 0; p < 10; p++) chk_log(delr_pkg::LOG_DEV_CONFIG, p[7:0], 1'b0);
    chk_log(8'h55, 8'h00, 1'b0);
    repeat (33) put_err(1'b1, 1'b1, 1'b1);
    quiet();
    chk_log(delr_pkg::LOG_WRITE_STREAM, 8'h00, 1'b0);
    repeat (65540) put_err(1'b1, 1'b0, 1'b1);
    quiet();
    chk_log(delr_pkg::LOG_READ_STREAM, 8'h00, 1'b0);
    repeat (5) put_err(1'b1, 1'b1, 1'b1);
    quiet();
    rst_i = 1'b1;
    @(negedge core_clk_i);
    rst_i = 1'b0;
    clr_log(1'b1);
    clr_log(1'b0);
    chk_log(delr_pkg::LOG_WRITE_STREAM, 8'h00, 1'b0);
    tally_and_finish();
  end
endmodule // delr_top_test
